// >>> logic/txc_supervisor.sv
`timescale 1ns/100ps
`include "txc_consts.svh"

// What this block does
// - Flag link timeout per transmitter after two seconds without messages.
// - Combined transmitter fault when link timeout or power-low is active.
// - Combined fault clears when both causes clear or auto RF mode changes.
// - Power-low fault follows the transmitter's forward-power-low alarm.
// - Transmitter faults evaluated regardless of automatic RF transfer state.
// - After changeover, flag fault if switch interlock contact not closed.
// - After changeover, flag fault if switch position differs from selection.
// - Automatic transfer putting backup on air raises RF changeover alarm.
// - Changeover alarm clears on main recovery or manual main selection change.
// - System interlock fault whenever the system interlock input is open.
// - Drive each transmitter's RF mute line and RF on/off command.
// - Switch feeds selected transmitter to antenna, standby to test load.
// - Standby muted unless maintenance mode with both interlocks intact.
// - Normally the main program source feeds both transmitters.
// - Auto audio transfer moves to backup when main source fails.
// - Main source recovery restores main under auto audio transfer.
// - Programmable audio level threshold and audio transfer delay.
// - Programmable RF transfer delay, triggered by combined transmitter fault (link timeout or power-low).
// - 15 V supply fault outside 13.5 V to 16.5 V.
// - 24 V supply fault below 21.6 V, clears above 22.8 V.
// - 3.3 V supply fault below 2.97 V, clears above 3.13 V.
// - 1.8 V supply fault below 1.62 V, clears above 1.71 V.
// - Position 1: transmitter 1 to antenna; position 2 the reverse.
// - After reset audio starts on main, backup only after delay.
// - Inhibit RF of dummy-load transmitter while dummy-load interlock open.
// - Main-audio-low fault while main level is below threshold.

module txc_supervisor #(
    parameter int TICK_CYC    = `TXC_CLK_HZ / 1000 * `TXC_TICK_MS,
    parameter int LINK_TO_CYC = `TXC_CLK_HZ / 1000 * `TXC_LINK_TO_MS,
    parameter int SETTLE_CYC  = `TXC_CLK_HZ / 1000 * `TXC_SW_SETTLE_MS
) (
    // Clock, reset, enable
    input  wire logic                I_CLK,
    input  wire logic                I_SYS_RST,
    input  wire logic                I_CE,
    // APB slave
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    // Transmitter links
    input  wire logic [1:0]          I_TX_MSG_VALID,
    input  wire logic [1:0]          I_TX_PWR_LOW,
    // Transfer switch and interlocks
    input  wire logic                I_SW_INTLK_CLOSED,
    input  wire logic                I_SW_AT_POS1,
    input  wire logic                I_SW_AT_POS2,
    input  wire logic                I_SYS_INTLK_OK,
    input  wire logic                I_DL_INTLK_OK,
    // Audio and supply levels
    input  wire logic [15:0]         I_MAIN_AUD_LEVEL,
    input  wire logic [15:0]         I_V15_MV,
    input  wire logic [15:0]         I_V24A_MV,
    input  wire logic [15:0]         I_V24B_MV,
    input  wire logic [15:0]         I_V3V3_MV,
    input  wire logic [15:0]         I_V1V8_MV,
    // Outputs
    output txc_pkg::txc_drive_t      O_DRIVE,
    output txc_pkg::txc_fault_t      O_FAULTS
);
    import txc_pkg::*;

    // ------------
    // Register file
    // ------------
    logic [`TXC_CTRL_W-1:0] ctrl_q;
    logic [15:0]            aud_thr_q;
    logic [15:0]            aud_dly_q;
    logic [15:0]            rf_dly_q;
    logic                   wr_en;
    logic                   rd_setup;
    logic                   rf_mode_chg;
    logic                   main_sel_chg;
    logic                   addr_ok;
    logic [31:0]            rd_mux;
    txc_fault_t             flt;
    logic                   onair_q;
    logic                   drv_pos_q;
    logic                   armed_q;
    logic                   aud_bk_q;
    txc_co_state_t          co_q;

    assign wr_en    = I_CE & PSEL & PENABLE & PWRITE & addr_ok;
    assign rd_setup = I_CE & PSEL & ~PENABLE;
    assign PREADY   = I_CE;
    assign PSLVERR  = PSEL & PENABLE & ~addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (PADDR)
            `TXC_OFS_CTRL:    rd_mux = {26'h0, ctrl_q};
            `TXC_OFS_AUD_THR: rd_mux = {16'h0, aud_thr_q};
            `TXC_OFS_AUD_DLY: rd_mux = {16'h0, aud_dly_q};
            `TXC_OFS_RF_DLY:  rd_mux = {16'h0, rf_dly_q};
            `TXC_OFS_FAULT:   rd_mux = {16'h0, flt};
            `TXC_OFS_STATE:   rd_mux = {26'h0, co_q, armed_q, aud_bk_q, drv_pos_q, onair_q};
            default:          addr_ok = 1'b0;
        endcase
    end

    // Manual edits of mode bits are events for the fault logic
    assign rf_mode_chg  = wr_en && (PADDR == `TXC_OFS_CTRL) &&
                          (PWDATA[`TXC_CTRL_AUTO_RF] != ctrl_q[`TXC_CTRL_AUTO_RF]);
    assign main_sel_chg = wr_en && (PADDR == `TXC_OFS_CTRL) &&
                          (PWDATA[`TXC_CTRL_MAIN_SEL] != ctrl_q[`TXC_CTRL_MAIN_SEL]);

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ctrl_q    <= `TXC_CTRL_RST;
            aud_thr_q <= `TXC_AUD_THR_RST;
            aud_dly_q <= `TXC_AUD_DLY_RST;
            rf_dly_q  <= `TXC_RF_DLY_RST;
        end else if (wr_en) begin
            case (PADDR)
                `TXC_OFS_CTRL:    ctrl_q    <= PWDATA[`TXC_CTRL_W-1:0];
                `TXC_OFS_AUD_THR: aud_thr_q <= PWDATA[15:0];
                `TXC_OFS_AUD_DLY: aud_dly_q <= PWDATA[15:0];
                `TXC_OFS_RF_DLY:  rf_dly_q  <= PWDATA[15:0];
                default:          ;
            endcase
        end
    end

    // Read data captured in setup so the access phase answers at once
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA <= rd_mux;
        end
    end

    // ------------
    // Millisecond tick for the programmable delays
    // ------------
    logic [31:0] tick_cnt_q;
    logic        tick;

    assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            tick_cnt_q <= 32'h0;
        end else if (I_CE) begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // ------------
    // Per-transmitter link and fault supervision
    // ------------
    logic [1:0] link_to;
    logic [1:0] cause;
    logic [1:0] cause_prev_q;
    logic [1:0] tx_fault_q;

    for (genvar i = 0; i < 2; i++) begin : g_tx
        logic [31:0] link_cnt_q;

        always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
            if (I_SYS_RST) begin
                link_cnt_q <= 32'h0;
            end else if (I_CE) begin
                if (I_TX_MSG_VALID[i]) begin
                    link_cnt_q <= 32'h0;
                end else if (link_cnt_q < 32'(LINK_TO_CYC)) begin
                    link_cnt_q <= link_cnt_q + 32'h1;
                end
            end
        end

        assign link_to[i] = (link_cnt_q >= 32'(LINK_TO_CYC));
        assign cause[i]   = link_to[i] | I_TX_PWR_LOW[i];

        // set on a new cause wins over a manual clear
        always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
            if (I_SYS_RST) begin
                cause_prev_q[i] <= 1'b0;
                tx_fault_q[i]   <= 1'b0;
            end else if (I_CE) begin
                cause_prev_q[i] <= cause[i];
                if (cause[i] & ~cause_prev_q[i]) begin
                    tx_fault_q[i] <= 1'b1;
                end else if (~cause[i] | rf_mode_chg) begin
                    tx_fault_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------
    // RF routing: on-air selection and automatic transfer
    // ------------
    logic        main_sel;
    logic        standby;
    logic        rf_go;
    logic [15:0] rf_ms_q;
    logic        rf_chg_q;

    assign main_sel = ctrl_q[`TXC_CTRL_MAIN_SEL];
    assign standby  = ~onair_q;
    // combined fault on the on-air transmitter, other transmitter must be healthy
    assign rf_go    = ctrl_q[`TXC_CTRL_AUTO_RF] & tx_fault_q[onair_q] &
                      ~tx_fault_q[standby] & (rf_ms_q >= rf_dly_q);

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rf_ms_q <= 16'h0;
        end else if (I_CE) begin
            if (~tx_fault_q[onair_q] | rf_go) begin
                rf_ms_q <= 16'h0;
            end else if (tick & (rf_ms_q != 16'hffff)) begin
                rf_ms_q <= rf_ms_q + 16'h1;
            end
        end
    end

    // selected main goes to air, manual choice overrides
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            onair_q <= 1'b0;
        end else if (I_CE) begin
            if (main_sel_chg) begin
                onair_q <= PWDATA[`TXC_CTRL_MAIN_SEL];
            end else if (rf_go) begin
                onair_q <= standby;
            end
        end
    end

    // changeover alarm, a manual main selection change wins over set
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rf_chg_q <= 1'b0;
        end else if (I_CE) begin
            if (rf_go & ~main_sel_chg & (standby == main_sel)) begin
                rf_chg_q <= 1'b0;
            end else if (rf_go & ~main_sel_chg & (onair_q == main_sel)) begin
                rf_chg_q <= 1'b1;
            end else if (main_sel_chg | ~tx_fault_q[main_sel]) begin
                rf_chg_q <= 1'b0;
            end
        end
    end

    // ------------
    // Transfer switch drive and post-changeover check
    // ------------
    logic [31:0] settle_q;
    logic        sw_intlk_q;
    logic        sw_pos_q;
    logic        pos_seen;

    // position 1 means transmitter 1 on air
    assign pos_seen = drv_pos_q ? (I_SW_AT_POS2 & ~I_SW_AT_POS1)
                                : (I_SW_AT_POS1 & ~I_SW_AT_POS2);

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            co_q      <= CO_IDLE;
            drv_pos_q <= 1'b0;
            settle_q  <= 32'h0;
        end else if (I_CE) begin
            case (co_q)
                CO_IDLE: begin
                    if (onair_q != drv_pos_q) begin
                        drv_pos_q <= onair_q;
                        settle_q  <= 32'h0;
                        co_q      <= CO_MOVE;
                    end
                end
                CO_MOVE: begin
                    if (settle_q >= 32'(SETTLE_CYC - 1)) begin
                        co_q <= CO_CHECK;
                    end else begin
                        settle_q <= settle_q + 32'h1;
                    end
                end
                CO_CHECK: co_q <= CO_IDLE;
                default:  co_q <= CO_IDLE;
            endcase
        end
    end

    // verdict held until the next changeover
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            armed_q    <= 1'b0;
            sw_intlk_q <= 1'b0;
            sw_pos_q   <= 1'b0;
        end else if (I_CE && co_q == CO_CHECK) begin
            armed_q    <= 1'b1;
            sw_intlk_q <= ~I_SW_INTLK_CLOSED;
            sw_pos_q   <= ~pos_seen;
        end
    end

    // ------------
    // Audio source selection
    // ------------
    logic        main_low;
    logic [15:0] aud_ms_q;

    assign main_low = (I_MAIN_AUD_LEVEL < aud_thr_q);

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            aud_ms_q <= 16'h0;
        end else if (I_CE) begin
            if (~main_low | aud_bk_q) begin
                aud_ms_q <= 16'h0;
            end else if (tick & (aud_ms_q != 16'hffff)) begin
                aud_ms_q <= aud_ms_q + 16'h1;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            aud_bk_q <= 1'b0;
        end else if (I_CE) begin
            if (~ctrl_q[`TXC_CTRL_AUTO_AUD]) begin
                aud_bk_q <= ctrl_q[`TXC_CTRL_AUD_BK];
            end else if (aud_bk_q) begin
                aud_bk_q <= main_low;
            // main failed for the full delay
            end else if (main_low & (aud_ms_q >= aud_dly_q)) begin
                aud_bk_q <= 1'b1;
            end
        end
    end

    // ------------
    // Supply monitors, hysteresis on all but the 15 V window
    // ------------
    logic s15_q;
    logic s24a_q;
    logic s24b_q;
    logic s33_q;
    logic s18_q;

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            s15_q  <= 1'b0;
            s24a_q <= 1'b0;
            s24b_q <= 1'b0;
            s33_q  <= 1'b0;
            s18_q  <= 1'b0;
        end else if (I_CE) begin
            s15_q  <= (I_V15_MV < `TXC_V15_LO_MV) | (I_V15_MV > `TXC_V15_HI_MV);
            s24a_q <= (I_V24A_MV < `TXC_V24_SET_MV) |
                      (s24a_q & (I_V24A_MV <= `TXC_V24_CLR_MV));
            s24b_q <= (I_V24B_MV < `TXC_V24_SET_MV) |
                      (s24b_q & (I_V24B_MV <= `TXC_V24_CLR_MV));
            s33_q  <= (I_V3V3_MV < `TXC_V3V3_SET_MV) |
                      (s33_q & (I_V3V3_MV <= `TXC_V3V3_CLR_MV));
            s18_q  <= (I_V1V8_MV < `TXC_V1V8_SET_MV) |
                      (s18_q & (I_V1V8_MV <= `TXC_V1V8_CLR_MV));
        end
    end

    // ------------
    // Fault collection
    // ------------
    always_comb begin
        flt                    = '0;
        flt.link_to            = link_to;
        flt.pwr_low            = I_TX_PWR_LOW;
        flt.tx_fault           = tx_fault_q;
        flt.sw_intlk           = sw_intlk_q & armed_q;
        flt.sw_pos             = sw_pos_q & armed_q;
        flt.rf_chg             = rf_chg_q;
        flt.sys_intlk          = ~I_SYS_INTLK_OK;
        flt.main_aud_low       = main_low;
        flt.sup_15v            = s15_q;
        flt.sup_24v_a          = s24a_q;
        flt.supply_24v_fault_b = s24b_q;
        flt.supply_3v3_fault   = s33_q;
        flt.sup_1v8            = s18_q;
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_FAULTS <= '0;
        end else if (I_CE) begin
            O_FAULTS <= flt;
        end
    end

    // ------------
    // RF mute, RF on and switch coil drive
    // ------------
    // Both mutes during switch travel so no RF hot-switches the coax
    logic [1:0] mute;
    logic       moving;

    assign moving = (co_q != CO_IDLE) | (onair_q != drv_pos_q);

    for (genvar i = 0; i < 2; i++) begin : g_rf
        // standby inhibited unless maintenance with interlocks
        assign mute[i] = moving | ~I_SYS_INTLK_OK |
                         ((i != 32'(drv_pos_q)) &
                          ~(ctrl_q[`TXC_CTRL_MAINT] & I_DL_INTLK_OK));
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_DRIVE <= '{mute: 2'b11, rf_on: 2'b00, pos1: 1'b0,
                         pos2: 1'b0, aud_backup: 1'b0};
        end else if (I_CE) begin
            O_DRIVE.mute       <= mute;
            O_DRIVE.rf_on      <= ~mute & {2{ctrl_q[`TXC_CTRL_RF_ON]}};
            O_DRIVE.pos1       <= ~drv_pos_q;
            O_DRIVE.pos2       <= drv_pos_q;
            O_DRIVE.aud_backup <= aud_bk_q;
        end
    end

endmodule

// >>> pkg/txc_consts.svh
`ifndef TXC_CONSTS_SVH
`define TXC_CONSTS_SVH

// ------------
// Register byte offsets
// ------------
`define TXC_OFS_CTRL      8'h00
`define TXC_OFS_AUD_THR   8'h04
`define TXC_OFS_AUD_DLY   8'h08
`define TXC_OFS_RF_DLY    8'h0c
`define TXC_OFS_FAULT     8'h10
`define TXC_OFS_STATE     8'h14

// ------------
// Control register fields and reset values
// ------------
`define TXC_CTRL_AUTO_RF  0
`define TXC_CTRL_AUTO_AUD 1
`define TXC_CTRL_MAIN_SEL 2
`define TXC_CTRL_MAINT    3
`define TXC_CTRL_RF_ON    4
`define TXC_CTRL_AUD_BK   5
`define TXC_CTRL_W        6
`define TXC_CTRL_RST      6'h13
`define TXC_AUD_THR_RST   16'h0100
`define TXC_AUD_DLY_RST   16'h2710
`define TXC_RF_DLY_RST    16'h03e8

// ------------
// Supply limits in millivolts
// ------------
`define TXC_V15_LO_MV     16'd13500
`define TXC_V15_HI_MV     16'd16500
`define TXC_V24_SET_MV    16'd21600
`define TXC_V24_CLR_MV    16'd22800
`define TXC_V3V3_SET_MV   16'd2970
`define TXC_V3V3_CLR_MV   16'd3130
`define TXC_V1V8_SET_MV   16'd1620
`define TXC_V1V8_CLR_MV   16'd1710

// ------------
// Timing
// ------------
`define TXC_CLK_HZ        20000000
`define TXC_TICK_MS       1
`define TXC_LINK_TO_MS    2000
`define TXC_SW_SETTLE_MS  100

`endif

// >>> pkg/txc_pkg.sv
package txc_pkg;

    typedef struct packed {
        logic [1:0] link_to;
        logic [1:0] pwr_low;
        logic [1:0] tx_fault;
        logic       sw_intlk;
        logic       sw_pos;
        logic       rf_chg;
        logic       sys_intlk;
        logic       main_aud_low;
        logic       sup_15v;
        logic       sup_24v_a;
        logic       supply_24v_fault_b;
        logic       supply_3v3_fault;
        logic       sup_1v8;
    } txc_fault_t;

    typedef struct packed {
        logic [1:0] mute;
        logic [1:0] rf_on;
        logic       pos1;
        logic       pos2;
        logic       aud_backup;
    } txc_drive_t;

    typedef enum logic [1:0] {
        CO_IDLE  = 2'b00,
        CO_MOVE  = 2'b01,
        CO_CHECK = 2'b10
    } txc_co_state_t;

endpackage

// >>> dv/txc_supervisor_checker.sv
`timescale 1ns/100ps
`include "txc_consts.svh"
module txc_supervisor_checker #(
    parameter int LINK_TO_CYC = 200
) (
    // Block inputs
    input wire logic        I_CLK,
    input wire logic        I_SYS_RST,
    input wire logic [1:0]  I_TX_MSG_VALID,
    input wire logic [1:0]  I_TX_PWR_LOW,
    input wire logic        I_SYS_INTLK_OK,
    input wire logic [15:0] I_V15_MV,
    input wire logic [15:0] I_V24A_MV,
    // Block outputs
    input wire txc_pkg::txc_drive_t O_DRIVE,
    input wire txc_pkg::txc_fault_t O_FAULTS
);
    import txc_pkg::*;
    int quiet_q;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // Saturates so the link figures are hit exactly once per silence
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST || I_TX_MSG_VALID[0]) begin
            quiet_q <= 0;
        end else if (quiet_q < LINK_TO_CYC + 8) begin
            quiet_q <= quiet_q + 1;
        end
    end
    sys_flag_a: assert property (!I_SYS_INTLK_OK [*3] |-> O_FAULTS.sys_intlk)
        else $error("system interlock fault missing");
    sys_mute_a: assert property (!I_SYS_INTLK_OK [*3] |-> O_DRIVE.mute == 2'b11)
        else $error("transmitters not muted on open interlock");
    rf_mute_a: assert property ((O_DRIVE.rf_on & O_DRIVE.mute) == 2'b00)
        else $error("rf on while muted");
    pos_excl_a: assert property (!(O_DRIVE.pos1 && O_DRIVE.pos2))
        else $error("both switch coils driven");
    pwr_low_a: assert property (I_TX_PWR_LOW[1] [*3] |-> O_FAULTS.pwr_low[1])
        else $error("power low fault missing");
    link_early_a: assert property (quiet_q == LINK_TO_CYC - 4 |-> !O_FAULTS.link_to[0])
        else $error("link timeout too early");
    link_late_a: assert property (quiet_q == LINK_TO_CYC + 4 |-> O_FAULTS.link_to[0])
        else $error("link timeout missing");
    link_clr_a: assert property (I_TX_MSG_VALID[0] |-> ##3 !O_FAULTS.link_to[0])
        else $error("link timeout not cleared by message");
    v15_hi_a: assert property ((I_V15_MV > `TXC_V15_HI_MV) [*3] |-> O_FAULTS.sup_15v)
        else $error("15 V high fault missing");
    v24_set_a: assert property ($rose(O_FAULTS.sup_24v_a) |->
        $past(I_V24A_MV, 2) < `TXC_V24_SET_MV) else $error("24 V fault set above limit");
    v24_clr_a: assert property ($fell(O_FAULTS.sup_24v_a) |->
        $past(I_V24A_MV, 2) > `TXC_V24_CLR_MV) else $error("24 V fault cleared too low");
endmodule
bind txc_supervisor txc_supervisor_checker #(.LINK_TO_CYC(LINK_TO_CYC))
    i_txc_supervisor_checker (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_TX_MSG_VALID(I_TX_MSG_VALID), .I_TX_PWR_LOW(I_TX_PWR_LOW),
    .I_SYS_INTLK_OK(I_SYS_INTLK_OK), .I_V15_MV(I_V15_MV), .I_V24A_MV(I_V24A_MV),
    .O_DRIVE(O_DRIVE), .O_FAULTS(O_FAULTS));

// >>> dv/txc_partner.sv
`timescale 1ns/100ps
module txc_partner #(
    parameter int GAP    = 50,
    parameter int TRAVEL = 6
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire txc_pkg::txc_drive_t drv,
    input  wire logic [1:0]          quiet,
    input  wire logic                stuck,
    output logic [1:0]               msg,
    output logic                     intlk,
    output logic                     pos1,
    output logic                     pos2
);
    import txc_pkg::*;
    int   gap_q;
    int   trv_q;
    logic at2_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= 0;
            msg <= 2'b00;
        end else begin
            gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
            msg <= {2{gap_q == 0}} & ~quiet;
        end
    end
    // latching coax switch
    // Contact opens in travel; a stuck switch never arrives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            at2_q <= 1'b0;
            trv_q <= 0;
            intlk <= 1'b1;
        end else if ((drv.pos1 ^ drv.pos2) && (drv.pos2 != at2_q)) begin
            intlk <= 1'b0;
            trv_q <= stuck ? 0 : trv_q + 1;
            if (trv_q == TRAVEL) begin
                at2_q <= drv.pos2;
            end
        end else begin
            intlk <= 1'b1;
            trv_q <= 0;
        end
    end
    assign pos1 = !at2_q;
    assign pos2 = at2_q;
endmodule

// >>> dv/txc_supervisor_test.sv
`timescale 1ns/100ps
`include "txc_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module txc_supervisor_test;
    import txc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, stuck = 0, sys_ok = 1, dl_ok = 1;
    logic pready, pslverr, sw_intlk, at1, at2;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, lfsr = 32'h1810;
    logic [1:0] msg, pwr_low = '0, quiet = '0;
    logic [15:0] aud = 16'h1000, v15 = 16'h3a98;
    logic [15:0] sup[4] = '{16'h5dc0, 16'h5dc0, 16'h0ce4, 16'h0708};
    logic [15:0] lo[4] = '{`TXC_V24_SET_MV, `TXC_V24_SET_MV, `TXC_V3V3_SET_MV, `TXC_V1V8_SET_MV};
    logic [15:0] hi[4] = '{`TXC_V24_CLR_MV, `TXC_V24_CLR_MV, `TXC_V3V3_CLR_MV, `TXC_V1V8_CLR_MV};
    logic [32:0] e, m, exp_q[$], msk_q[$];
    txc_drive_t drv;
    txc_fault_t flt;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    txc_supervisor #(.TICK_CYC(4), .LINK_TO_CYC(200), .SETTLE_CYC(10)) i_txc_supervisor (
        .I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .I_TX_MSG_VALID(msg), .I_TX_PWR_LOW(pwr_low), .I_SW_INTLK_CLOSED(sw_intlk),
        .I_SW_AT_POS1(at1), .I_SW_AT_POS2(at2), .I_SYS_INTLK_OK(sys_ok), .I_DL_INTLK_OK(dl_ok),
        .I_MAIN_AUD_LEVEL(aud), .I_V15_MV(v15), .I_V24A_MV(sup[0]), .I_V24B_MV(sup[1]),
        .I_V3V3_MV(sup[2]), .I_V1V8_MV(sup[3]), .O_DRIVE(drv), .O_FAULTS(flt));
    txc_partner i_txc_partner (.clk(clk), .rst(rst), .drv(drv), .quiet(quiet),
        .stuck(stuck), .msg(msg), .intlk(sw_intlk), .pos1(at1), .pos2(at2));
    // Reads checked against the oldest note
    always @(posedge clk) begin
        cyc++;
        if (psel && pen && pready && !pwr && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK({pslverr, prdata} & m, e & m)
        end
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] ex, input logic [32:0] mk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            exp_q.push_back(ex);
            msk_q.push_back(mk);
        end
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0, '0);
    endtask
    task automatic fault(input logic [15:0] ex, input logic [15:0] mk);
        apb(1'b0, `TXC_OFS_FAULT, '0, {17'h0, ex}, {17'h0, mk});
    endtask
    task automatic state(input logic [5:0] ex, input logic [5:0] mk);
        apb(1'b0, `TXC_OFS_STATE, '0, {27'h0, ex}, {27'h0, mk});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(20);
        rst <= 1'b0;
        tick(1);
        fault(16'h0000, 16'hffff);
        apb(1'b0, 8'h18, '0, 33'h100000000, 33'h1ffffffff);
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            v15 <= (i == 0) ? `TXC_V15_HI_MV : (i == 1) ? `TXC_V15_LO_MV - 16'h1
                 : 16'h2ee0 + {3'h0, lfsr[12:0]};
            tick(3);
            fault({v15 < `TXC_V15_LO_MV || v15 > `TXC_V15_HI_MV, 4'h0}, 16'h10);
        end
        v15 <= 16'h3a98;
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 4; s++) begin
                sup[k] <= (s == 0) ? lo[k] - 16'h1 : (s == 1) ? hi[k]
                        : (s == 2) ? hi[k] + 16'h1 : lo[k];
                tick(3);
                fault((s < 2) ? 16'h1 << (3 - k) : 16'h0, 16'h1 << (3 - k));
            end
        end
        $display("test done: supplies");
        sys_ok <= 1'b0;
        tick(3);
        fault(16'h0040, 16'h0040);
        sys_ok <= 1'b1;
        tick(3);
        `CHK({drv.mute, drv.rf_on}, 4'b1001)
        wr(`TXC_OFS_CTRL, 32'h1b);
        tick(3);
        `CHK(drv.mute, 2'b00)
        dl_ok <= 1'b0;
        tick(3);
        `CHK(drv.mute, 2'b10)
        dl_ok <= 1'b1;
        wr(`TXC_OFS_CTRL, 32'h13);
        $display("test done: interlocks");
        pwr_low <= 2'b10;
        tick(3);
        fault(16'h2800, 16'h3c00);
        wr(`TXC_OFS_CTRL, 32'h12);
        tick(2);
        fault(16'h2000, 16'h3c00);
        pwr_low <= 2'b00;
        tick(3);
        fault(16'h0000, 16'h3c00);
        wr(`TXC_OFS_CTRL, 32'h13);
        stuck <= 1'b1;
        wr(`TXC_OFS_CTRL, 32'h17);
        tick(30);
        fault(16'h0300, 16'h0380);
        state(6'h0b, 6'h3f);
        `CHK({drv.pos1, drv.pos2}, 2'b01)
        wr(`TXC_OFS_CTRL, 32'h13);
        stuck <= 1'b0;
        tick(30);
        fault(16'h0000, 16'h0380);
        $display("test done: changeover");
        wr(`TXC_OFS_RF_DLY, 32'h3);
        quiet <= 2'b01;
        tick(215);
        fault(16'h4400, 16'h4400);
        tick(60);
        fault(16'h4480, 16'h4780);
        state(6'h0b, 6'h3f);
        quiet <= 2'b00;
        tick(60);
        fault(16'h0000, 16'hc780);
        $display("test done: rf transfer");
        wr(`TXC_OFS_AUD_DLY, 32'h5);
        aud <= 16'h00ff;
        tick(3);
        fault(16'h0020, 16'h0020);
        state(6'h00, 6'h04);
        tick(25);
        state(6'h04, 6'h04);
        `CHK(drv.aud_backup, 1'b1)
        aud <= 16'h0100;
        tick(3);
        state(6'h00, 6'h04);
        wr(`TXC_OFS_CTRL, 32'h31);
        tick(2);
        `CHK(drv.aud_backup, 1'b1)
        $display("test done: audio");
        tick(2);
        results();
    end
endmodule
